// ### pcpio_pkg.sv
// Purpose: constants for the priority crossbar and port pin block
// Assumes: APB word registers, four 8-bit ports
// Notes: offsets are byte addresses
package pcpio_pkg;
   localparam int NPORT = 4;
   localparam int NPIN = 32;
   localparam int NSIG = 8;
   localparam int RDLAT = 1;
   localparam logic [7:0] OFF_CROSSBAR_CONFIG_0 = 8'h00;
   localparam logic [7:0] OFF_CROSSBAR_CONFIG_1 = 8'h04;
   localparam logic [7:0] OFF_CROSSBAR_CONFIG_2 = 8'h08;
   localparam logic [7:0] OFF_CROSSBAR_CONFIG_3 = 8'h0C;
   localparam logic [7:0] OFF_DATA = 8'h10;
   localparam logic [7:0] OFF_MDOUT = 8'h14;
   localparam logic [7:0] OFF_MDIN = 8'h18;
   localparam logic [7:0] OFF_RMW = 8'h1C;
   localparam logic [7:0] OFF_UMODE = 8'h20;
   localparam logic [7:0] OFF_ALLOC = 8'h24;
   localparam int B_UART0 = 2;
   localparam int B_SPI = 1;
   localparam int B_SMB = 0;
   localparam int B_UART1 = 2;
   localparam int B_CROSSBAR_GLOBAL_ENABLE = 4;
   localparam int B_WPUD = 7;
   localparam logic [31:0] RST_DATA = 32'hFFFFFFFF;
   localparam logic [31:0] RST_MDOUT = 32'h00000000;
   localparam logic [31:0] RST_MDIN = 32'hFFFFFFFF;
   localparam logic [7:0] RST_XBR = 8'h00;
   // signal slots in priority order
   localparam int S_TX0 = 0;
   localparam int S_RX0 = 1;
   localparam int S_SCK = 2;
   localparam int S_MISO = 3;
   localparam int S_MOSI = 4;
   localparam int S_NSS = 5;
   localparam int S_SDA = 6;
   localparam int S_SCL = 7;
endpackage

// ### pcpio_top.sv
// Purpose: priority crossbar, port data/mode registers and pin drivers
// Assumes: pclk 125 MHz, presetn async active low, APB slave
// Notes: maps first uart, spi, smbus and second uart receive/transmit
`timescale 1ns/1ps
// How it works
// - only enabled peripherals reach pins
// - first uart always on pins 0 and 1
// - disabled peripheral has no pin
// - serial peripheral signals allocated together
// - free pins are gpio via data register
// - allocated pins ignore data register writes
// - normal reads return pin levels
// - read-modify-write read returns latch
// - drivers off until global enable set
// - peripheral inputs have drivers forced off
// - push-pull drives both levels
// - open-drain drives low, else released
// - mode bit one push-pull, zero open-drain
// - reset leaves all pins open-drain
// - sda, scl, receive with its uart_mode0 bit set forced open-drain
// - pullups on at reset, global disable
// - pullup off where pin driven low
// - analog pins on ports 1-3 lose pullup
// - analog pin reads zero
// - analog pins skipped, except port 2 pins 0-1
module pcpio_top import pcpio_pkg::*; (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral side, slot order tx0 rx0 sck miso mosi nss sda scl
   input wire logic [NSIG-1:0] periph_out,
   input wire logic [NSIG-1:0] periph_oe,
   input wire logic [NSIG-1:0] periph_is_input,
   output logic [NSIG-1:0] periph_in,
   // second uart
   input wire logic second_uart_transmit_out,
   output logic second_uart_receive_in,
   // pins
   input wire logic [NPIN-1:0] pin_in,
   output logic [NPIN-1:0] pin_out,
   output logic [NPIN-1:0] pin_oe,
   output logic [NPIN-1:0] pin_pullup_en
);
   logic [7:0] crossbar_config_0, crossbar_config_1, crossbar_config_2, crossbar_config_3;
   logic [31:0] port_data, port_output_mode, port_input_mode;
   logic [1:0] uart_mode0;
   logic rmw;
   logic [31:0] pin_s1, pin_s2;
   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 32'h00000000;
         pin_s2 <= 32'h00000000;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end
   // ----------------------------------------
   // crossbar allocation
   // ----------------------------------------
   // ten signals: eight slots plus second uart tx/rx
   logic [9:0] sig_en;
   logic [4:0] sig_pin [10];
   logic [9:0] sig_ok;
   logic [NPIN-1:0] eligible;
   always_comb begin
      eligible = port_input_mode;
      eligible[0 +: 8] = 8'hFF;
      eligible[16] = 1'b1;
      eligible[17] = 1'b1;
      sig_en = '0;
      sig_en[S_TX0] = crossbar_config_0[B_UART0];
      sig_en[S_RX0] = crossbar_config_0[B_UART0];
      sig_en[S_SCK +: 4] = {4{crossbar_config_0[B_SPI]}};
      sig_en[S_SDA +: 2] = {2{crossbar_config_0[B_SMB]}};
      sig_en[8 +: 2] = {2{crossbar_config_2[B_UART1]}};
   end
   always_comb begin
      logic [NPIN-1:0] used;
      logic found;
      used = '0;
      found = 1'b0;
      for (int s = 0; s < 10; s++) begin
         sig_pin[s] = 5'h00;
         sig_ok[s] = 1'b0;
         found = 1'b0;
         for (int p = 0; p < NPIN; p++) begin
            if (sig_en[s] && !found && eligible[p] && !used[p]) begin
               found = 1'b1;
               sig_pin[s] = 5'(p);
               sig_ok[s] = 1'b1;
               used[p] = 1'b1;
            end
         end
      end
   end
   // per-pin owner: which signal, if any
   logic [NPIN-1:0] alloc, own_in, own_od, own_val, own_oe;
   always_comb begin
      for (int p = 0; p < NPIN; p++) begin
         alloc[p] = 1'b0;
         own_in[p] = 1'b0;
         own_od[p] = 1'b0;
         own_val[p] = 1'b1;
         own_oe[p] = 1'b0;
         for (int s = 0; s < 10; s++) begin
            if (sig_ok[s] && sig_pin[s] == 5'(p)) begin
               alloc[p] = 1'b1;
               if (s < NSIG) begin
                  own_in[p] = periph_is_input[s];
                  own_val[p] = periph_out[s];
                  own_oe[p] = periph_oe[s];
               end else begin
                  own_in[p] = (s == 9);
                  own_val[p] = second_uart_transmit_out;
                  own_oe[p] = (s == 8);
               end
               own_od[p] = (s == S_SDA) || (s == S_SCL)
                  || (s == S_RX0 && uart_mode0[0]) || (s == 9 && uart_mode0[1]);
            end
         end
      end
   end
   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   logic [NPIN-1:0] lvl, pp;
   logic crossbar_global_enable;
   assign crossbar_global_enable = crossbar_config_2[B_CROSSBAR_GLOBAL_ENABLE];
   always_comb begin
      for (int p = 0; p < NPIN; p++) begin
         lvl[p] = alloc[p] ? own_val[p] : port_data[p];
         pp[p] = port_output_mode[p] && !own_od[p];
         if (!crossbar_global_enable || (alloc[p] && own_in[p]) || (alloc[p] && !own_oe[p])) begin
            pin_oe[p] = 1'b0;
         end else begin
            pin_oe[p] = pp[p] || !lvl[p];
         end
         pin_out[p] = pin_oe[p] & lvl[p];
         pin_pullup_en[p] = !crossbar_config_2[B_WPUD]
            && !(pin_oe[p] && !lvl[p])
            && !(p >= 8 && !port_input_mode[p]);
      end
   end
   logic [31:0] pin_rd;
   assign pin_rd = pin_s2 & port_input_mode;
   always_comb begin
      periph_in = '0;
      second_uart_receive_in = 1'b1;
      for (int s = 0; s < NSIG; s++) begin
         if (sig_ok[s]) begin
            periph_in[s] = pin_rd[sig_pin[s]];
         end
      end
      if (sig_ok[9]) begin
         second_uart_receive_in = pin_rd[sig_pin[9]];
      end
   end
   // ----------------------------------------
   // apb registers
   // ----------------------------------------
   logic wr_en, rd_en;
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   logic addr_ok;
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFF_ALLOC);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crossbar_config_0 <= RST_XBR;
         crossbar_config_1 <= RST_XBR;
         crossbar_config_2 <= RST_XBR;
         crossbar_config_3 <= RST_XBR;
         port_data <= RST_DATA;
         port_output_mode <= RST_MDOUT;
         port_input_mode <= RST_MDIN;
         rmw <= 1'b0;
         uart_mode0 <= 2'b00;
      end else if (wr_en) begin
         unique case (paddr)
            OFF_CROSSBAR_CONFIG_0: crossbar_config_0 <= pwdata[7:0];
            OFF_CROSSBAR_CONFIG_1: crossbar_config_1 <= pwdata[7:0];
            OFF_CROSSBAR_CONFIG_2: crossbar_config_2 <= pwdata[7:0];
            OFF_CROSSBAR_CONFIG_3: crossbar_config_3 <= pwdata[7:0];
            OFF_DATA: port_data <= pwdata; // latch always stored, pin unaffected if allocated
            OFF_MDOUT: port_output_mode <= pwdata;
            OFF_MDIN: port_input_mode <= {pwdata[31:8], 8'hFF};
            OFF_RMW: rmw <= pwdata[0];
            OFF_UMODE: uart_mode0 <= pwdata[1:0];
            default: ;
         endcase
      end
   end
   // read data registered at the setup phase edge, one cycle before the sampling edge
   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h00000000;
      unique case (paddr)
         OFF_CROSSBAR_CONFIG_0: next_prdata = {24'h000000, crossbar_config_0};
         OFF_CROSSBAR_CONFIG_1: next_prdata = {24'h000000, crossbar_config_1};
         OFF_CROSSBAR_CONFIG_2: next_prdata = {24'h000000, crossbar_config_2};
         OFF_CROSSBAR_CONFIG_3: next_prdata = {24'h000000, crossbar_config_3};
         OFF_DATA: next_prdata = rmw ? port_data : pin_rd;
         OFF_MDOUT: next_prdata = port_output_mode;
         OFF_MDIN: next_prdata = port_input_mode;
         OFF_RMW: next_prdata = {31'h00000000, rmw};
         OFF_UMODE: next_prdata = {30'h00000000, uart_mode0};
         OFF_ALLOC: next_prdata = alloc;
         default: next_prdata = 32'h00000000;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_drv_off;
      @(posedge pclk) disable iff (!presetn) !crossbar_global_enable |-> pin_oe == 32'h00000000;
   endproperty
   a_drv_off: assert property (p_drv_off) else $error("driver on while crossbar off");
   property p_uart0;
      @(posedge pclk) disable iff (!presetn)
         crossbar_config_0[B_UART0] |-> alloc[1:0] == 2'b11 && sig_pin[0] == 5'h00
         && sig_pin[1] == 5'h01;
   endproperty
   a_uart0: assert property (p_uart0) else $error("first uart not on pins 0 and 1");
   property p_none;
      @(posedge pclk) disable iff (!presetn) sig_en == 10'h000 |-> alloc == 32'h00000000;
   endproperty
   a_none: assert property (p_none) else $error("pin allocated with nothing enabled");
   property p_od_high;
      @(posedge pclk) disable iff (!presetn)
         (crossbar_global_enable && !alloc[8] && !port_output_mode[8] && port_data[8]) |-> !pin_oe[8];
   endproperty
   a_od_high: assert property (p_od_high) else $error("open-drain one drives pin");
   property p_pp;
      @(posedge pclk) disable iff (!presetn)
         (crossbar_global_enable && !alloc[9] && port_output_mode[9]) |-> pin_oe[9] && pin_out[9] == port_data[9];
   endproperty
   a_pp: assert property (p_pp) else $error("push-pull not driving data");
   property p_pull_low;
      @(posedge pclk) disable iff (!presetn) (pin_oe[3] && !pin_out[3]) |-> !pin_pullup_en[3];
   endproperty
   a_pull_low: assert property (p_pull_low) else $error("pullup on while driving low");
   property p_analog;
      @(posedge pclk) disable iff (!presetn)
         !port_input_mode[24] |-> !pin_pullup_en[24] && !pin_rd[24] && !alloc[24];
   endproperty
   a_analog: assert property (p_analog) else $error("analog pin not isolated");
   property p_rmw;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !pwrite && paddr == OFF_DATA && rmw) |=> prdata == $past(port_data);
   endproperty
   a_rmw: assert property (p_rmw) else $error("rmw read not from latch");
   property p_wpud;
      @(posedge pclk) disable iff (!presetn) crossbar_config_2[B_WPUD] |-> pin_pullup_en == 0;
   endproperty
   a_wpud: assert property (p_wpud) else $error("pullup on despite global disable");
   property p_pull_on;
      @(posedge pclk) disable iff (!presetn)
         (!crossbar_config_2[B_WPUD] && !pin_oe[5]) |-> pin_pullup_en[5];
   endproperty
   a_pull_on: assert property (p_pull_on) else $error("pullup off on idle port 0 pin");
   // ----------------------------------------
   // allocation checks
   // ----------------------------------------
   // a half-routed serial port would leave a peer talking to a floating line
   property p_pair;
      @(posedge pclk) disable iff (!presetn)
         (sig_ok[S_SCK +: 4] == 4'h0 || sig_ok[S_SCK +: 4] == 4'hF) && sig_ok[S_TX0] == sig_ok[S_RX0]
         && sig_ok[S_SDA] == sig_ok[S_SCL] && sig_ok[8] == sig_ok[9];
   endproperty
   a_pair: assert property (p_pair) else $error("serial port only partly allocated");
   property p_enable_only;
      @(posedge pclk) disable iff (!presetn)
         !crossbar_config_0[B_SPI] |-> sig_ok[S_SCK +: 4] == 4'h0;
   endproperty
   a_enable_only: assert property (p_enable_only) else $error("disabled spi has pins");
   property p_port0_first;
      @(posedge pclk) disable iff (!presetn)
         (crossbar_config_0[B_SPI] && !crossbar_config_0[B_UART0]) |-> sig_pin[S_SCK] == 5'h00;
   endproperty
   a_port0_first: assert property (p_port0_first) else $error("spi not from pin 0");
   property p_spi_after_uart;
      @(posedge pclk) disable iff (!presetn)
         (crossbar_config_0[B_UART0] && crossbar_config_0[B_SPI]) |-> sig_pin[S_SCK] == 5'h02;
   endproperty
   a_spi_after_uart: assert property (p_spi_after_uart) else $error("spi not after uart");
   property p_uart1_after;
      @(posedge pclk) disable iff (!presetn)
         (sig_ok[S_SCL] && sig_ok[8]) |-> sig_pin[8] > sig_pin[S_SCL];
   endproperty
   a_uart1_after: assert property (p_uart1_after) else $error("second uart out of order");
   property p_skip;
      @(posedge pclk) disable iff (!presetn) !port_input_mode[8] |-> !alloc[8];
   endproperty
   a_skip: assert property (p_skip) else $error("analog pin allocated");
   // port 0 has no analog use, so its pins stay digital
   property p_mdin_low;
      @(posedge pclk) disable iff (!presetn) port_input_mode[7:0] == 8'hFF;
   endproperty
   a_mdin_low: assert property (p_mdin_low) else $error("port 0 pin made analog");
   // ----------------------------------------
   // driver and read path checks
   // ----------------------------------------
   property p_in_off;
      @(posedge pclk) disable iff (!presetn)
         (alloc & own_in & pin_oe) == 32'h00000000;
   endproperty
   a_in_off: assert property (p_in_off) else $error("driver on a routed input");
   property p_uart1_in;
      @(posedge pclk) disable iff (!presetn) sig_ok[9] |-> !pin_oe[sig_pin[9]];
   endproperty
   a_uart1_in: assert property (p_uart1_in) else $error("second receive pin driven");
   property p_od_forced;
      @(posedge pclk) disable iff (!presetn)
         (pin_oe & pin_out & own_od) == 32'h00000000;
   endproperty
   a_od_forced: assert property (p_od_forced) else $error("forced open-drain driven high");
   property p_alloc_val;
      @(posedge pclk) disable iff (!presetn)
         (sig_ok[S_TX0] && pin_oe[0]) |-> pin_out[0] == periph_out[S_TX0];
   endproperty
   a_alloc_val: assert property (p_alloc_val) else $error("routed pin not from peripheral");
   property p_gpio;
      @(posedge pclk) disable iff (!presetn)
         (crossbar_global_enable && !alloc[12] && port_output_mode[12]) |-> pin_oe[12] && pin_out[12] == port_data[12];
   endproperty
   a_gpio: assert property (p_gpio) else $error("free pin not from data latch");
   property p_mode_od;
      @(posedge pclk) disable iff (!presetn)
         (crossbar_global_enable && !alloc[20] && !port_output_mode[20] && !port_data[20]) |-> pin_oe[20] && !pin_out[20];
   endproperty
   a_mode_od: assert property (p_mode_od) else $error("open-drain zero not driven low");
   property p_read_pin;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !pwrite && paddr == OFF_DATA && !rmw) |=> prdata == $past(pin_rd);
   endproperty
   a_read_pin: assert property (p_read_pin) else $error("data read not from pins");
   property p_analog_rd;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && !pwrite && paddr == OFF_DATA && !rmw && !port_input_mode[12])
         |=> !prdata[12];
   endproperty
   a_analog_rd: assert property (p_analog_rd) else $error("analog pin reads one");
   property p_rx_route;
      @(posedge pclk) disable iff (!presetn) sig_ok[S_RX0] |-> periph_in[S_RX0] == pin_rd[1];
   endproperty
   a_rx_route: assert property (p_rx_route) else $error("receive not from pin 1");
   c_uart: cover property (@(posedge pclk) crossbar_config_0[B_UART0] && crossbar_global_enable);
   c_spi: cover property (@(posedge pclk) crossbar_config_0[B_SPI] && crossbar_config_0[B_UART0]);
   c_smb: cover property (@(posedge pclk) sig_ok[S_SCL] && crossbar_global_enable);
   c_rmw: cover property (@(posedge pclk) rd_en && paddr == OFF_DATA && rmw);
   c_uart1: cover property (@(posedge pclk) sig_ok[9] && crossbar_global_enable);
endmodule

// ### pcpio_far.sv
// Purpose: far side model, on-chip peripherals and external pin wiring
// Assumes: pin level is own driver, then external driver, then pullup
// Notes: a floating pin toggles so a stale level never passes
`timescale 1ns/1ps
module pcpio_far import pcpio_pkg::*; (
   // clock
   input wire logic pclk,
   // pins
   input wire logic [NPIN-1:0] pin_out,
   input wire logic [NPIN-1:0] pin_oe,
   input wire logic [NPIN-1:0] pin_pullup_en,
   input wire logic [NPIN-1:0] ext_en,
   input wire logic [NPIN-1:0] ext_val,
   output logic [NPIN-1:0] pin_in,
   // peripherals
   input wire logic [NSIG-1:0] slot_val,
   output logic [NSIG-1:0] periph_out,
   output logic [NSIG-1:0] periph_oe,
   output logic [NSIG-1:0] periph_is_input
);
   logic tog = 1'b0;

   always_ff @(posedge pclk) begin
      tog <= ~tog;
   end

   // receive, miso and nss are inputs; sda and scl always try to drive
   assign periph_is_input = 8'h2A;
   assign periph_oe = ~periph_is_input;
   assign periph_out = slot_val;

   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
         else pin_in[i] = tog ^ i[0];
      end
   end
endmodule

// ### test_priority_crossbar_port_io.sv
// Purpose: self-checking bench for the crossbar and port pin block
// Assumes: apb slave answers on pready, pins resolved by the far model
// Notes: pin reads lag two cycles, so checks wait through settle
`timescale 1ns/1ps
module test_priority_crossbar_port_io import pcpio_pkg::*;;
   // ----------------
   // signals
   // ----------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, second_uart_receive_in;
   logic second_uart_transmit_out = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [NSIG-1:0] periph_out, periph_oe, periph_is_input, periph_in;
   logic [NSIG-1:0] slot_val = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [NPIN-1:0] pin_in, pin_out, pin_oe, pin_pullup_en;
   logic [NPIN-1:0] ext_en = 32'h00000000;
   logic [NPIN-1:0] ext_val = 32'h00000000;
   int n_mismatch = 0;
   int check_count = 0;

   always #4 pclk = ~pclk;

   pcpio_top pcpio_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .periph_out, .periph_oe, .periph_is_input, .periph_in,
      .second_uart_transmit_out, .second_uart_receive_in, .pin_in, .pin_out, .pin_oe,
      .pin_pullup_en);
   pcpio_far pcpio_far_inst (.pclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val,
      .pin_in, .slot_val, .periph_out, .periph_oe, .periph_is_input);

   // ----------------
   // tasks
   // ----------------
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // the watchdog bounds a slave that never answers
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h00000000, q);
      chk($sformatf("reg %h", a), q, exp);
   endtask

   task settle;
      repeat (3) @(negedge pclk);
   endtask

   task report_and_stop;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      report_and_stop;
   end

   // ----------------
   // tests
   // ----------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFF_MDOUT, 32'h00000000);
      rd(OFF_MDIN, 32'hFFFFFFFF);
      rd(OFF_DATA, 32'hFFFFFFFF);
      rd(8'h40, 32'h00000000);
      wr(OFF_DATA, 32'h0F55FFFF);
      wr(OFF_MDOUT, 32'h00FF0000);
      settle;
      chk("oe", pin_oe, 32'h00000000);
      chk("pullup", pin_pullup_en, 32'hFFFFFFFF);
      wr(OFF_CROSSBAR_CONFIG_2, 32'h00000010);
      settle;
      chk("oe", pin_oe, 32'hF0FF0000);
      chk("out", pin_out, 32'h00550000);
      chk("pullup", pin_pullup_en, 32'h0F55FFFF);
      @(posedge pclk);
      ext_en <= 32'h01000000;
      settle;
      rd(OFF_DATA, 32'h0E55FFFF);
      wr(OFF_RMW, 32'h00000001);
      rd(OFF_DATA, 32'h0F55FFFF);
      wr(OFF_RMW, 32'h00000000);
      wr(OFF_MDIN, 32'hFFFFFE00);
      rd(OFF_MDIN, 32'hFFFFFEFF);
      settle;
      rd(OFF_DATA, 32'h0E55FEFF);
      chk("pullup", pin_pullup_en, 32'h0F55FEFF);
      // receive lines held low from outside
      @(posedge pclk);
      ext_en <= 32'h00000402;
      slot_val <= 8'h41;
      second_uart_transmit_out <= 1'b0;
      wr(OFF_DATA, 32'hFFFFFFFC);
      wr(OFF_MDOUT, 32'h00000007);
      wr(OFF_CROSSBAR_CONFIG_0, 32'h00000005);
      settle;
      rd(OFF_ALLOC, 32'h0000000F);
      chk("low pins", {16'h0000, pin_oe[3:0], pin_out[3:0], periph_in}, 32'h00009141);
      wr(OFF_CROSSBAR_CONFIG_0, 32'h00000007);
      wr(OFF_CROSSBAR_CONFIG_2, 32'h00000014);
      settle;
      rd(OFF_ALLOC, 32'h000006FF);
      chk("uart1", {28'h0000000, pin_oe[10:8], second_uart_receive_in}, 32'h00000004);
      wr(OFF_CROSSBAR_CONFIG_0, 32'h00000000);
      wr(OFF_CROSSBAR_CONFIG_2, 32'h00000010);
      settle;
      rd(OFF_ALLOC, 32'h00000000);
      chk("freed", {19'h00000, periph_in, second_uart_receive_in, pin_oe[1:0], pin_out[1:0]},
         32'h0000001C);
      wr(OFF_CROSSBAR_CONFIG_2, 32'h00000090);
      settle;
      chk("pullup", pin_pullup_en, 32'h00000000);
      wr(OFF_CROSSBAR_CONFIG_2, 32'h00000000);
      settle;
      chk("oe", pin_oe, 32'h00000000);
      report_and_stop;
   end
endmodule
